// *** aar_ability_regs.sv ***
// Added by the designer: the AXI4-Lite interface to the registers.
module aar_ability_regs
	import aar_pkg::*;
#(
	parameter int unsigned ADDR_W            = 8,
	parameter bit          NEXT_PAGE_SUPPORT = 1'b1
) (
	input  wire logic                clock,
	input  wire logic                nrst,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]   awaddr,
	input  wire logic                awvalid,
	output      logic                awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output      logic                wready,
	output      logic [1:0]          bresp,
	output      logic                bvalid,
	input  wire logic                bready,
	input  wire logic [ADDR_W-1:0]   araddr,
	input  wire logic                arvalid,
	output      logic                arready,
	output      logic [31:0]         rdata,
	output      logic [1:0]          rresp,
	output      logic                rvalid,
	input  wire logic                rready,
	// Negotiation engine side
	input  wire logic [STRAP_W-1:0]  strapAbility,
	input  wire logic                anComplete,
	input  wire logic                partnerPageValid,
	input  wire aar_partner_t        partnerPageIn,
	input  wire logic                parallelDetectFault,
	input  wire logic                partnerNpAble,
	input  wire logic                partnerAnAble,
	output      aar_local_t          advertAbility
);

	// Refuse address widths that cannot hold the map
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 32");
	end

	localparam int unsigned IDX_W = ADDR_W - 2;

	logic              awHeldQ;
	logic [IDX_W-1:0]  awIdxQ;
	logic              wHeldQ;
	logic [15:0]       wDataQ;
	logic [1:0]        wStrbQ;
	logic              bvalidQ;
	logic [1:0]        brespQ;
	logic              rvalidQ;
	logic [1:0]        rrespQ;
	logic [31:0]       rdataQ;
	logic              strapDoneQ;
	aar_local_t        localQ;
	logic [15:0]       localWr;
	aar_partner_t      partnerQ;
	logic              faultQ;
	logic              pageRxQ;
	logic              lpNpQ;
	logic              lpAnQ;
	logic [15:0]       expWord;
	logic [IDX_W-1:0]  arIdx;
	logic [15:0]       rdMux;
	logic              rdHit;
	logic              awFire;
	logic              wFire;
	logic              arFire;
	logic              commit;
	logic              commitLocal;
	logic              wrHit;
	logic              strapLoad;
	logic              capPartner;
	logic              clrExp;

	// Handshake terms
	assign awready = !awHeldQ && !bvalidQ;
	assign wready  = !wHeldQ && !bvalidQ;
	assign arready = !rvalidQ;
	assign awFire  = awvalid && awready;
	assign wFire   = wvalid && wready;
	assign arFire  = arvalid && arready;
	assign commit  = awHeldQ && wHeldQ;
	assign arIdx   = araddr[ADDR_W-1:2];

	assign bvalid = bvalidQ;
	assign bresp  = brespQ;
	assign rvalid = rvalidQ;
	assign rresp  = rrespQ;
	assign rdata  = rdataQ;

	// Write address capture
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			awHeldQ <= 1'b0;
			awIdxQ  <= '0;
		end else if (awFire) begin
			awHeldQ <= 1'b1;
			awIdxQ  <= awaddr[ADDR_W-1:2];
		end else if (commit) begin
			awHeldQ <= 1'b0;
		end
	end

	// Write data capture, low half only carries register bits
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wHeldQ <= 1'b0;
			wDataQ <= 16'h0000;
			wStrbQ <= 2'h0;
		end else if (wFire) begin
			wHeldQ <= 1'b1;
			wDataQ <= wdata[15:0];
			wStrbQ <= wstrb[1:0];
		end else if (commit) begin
			wHeldQ <= 1'b0;
		end
	end

	// Write decode
	assign wrHit = (awIdxQ == IDX_W'(IDX_LOCAL)) || (awIdxQ == IDX_W'(IDX_PARTNER))
		|| (awIdxQ == IDX_W'(IDX_EXP));
	assign commitLocal = commit && (awIdxQ == IDX_W'(IDX_LOCAL));

	// Write response; read-only targets accept and ignore
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bvalidQ <= 1'b0;
			brespQ  <= RESP_OKAY;
		end else if (commit) begin
			bvalidQ <= 1'b1;
			brespQ  <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalidQ <= 1'b0;
		end
	end

	// Byte-lane merge of the local word
	for (genvar lane = 0; lane < 2; lane++) begin : g_lane
		assign localWr[lane*8 +: 8] = wStrbQ[lane]
			? ((wDataQ[lane*8 +: 8] & LOCAL_WR_MASK[lane*8 +: 8])
				| (localQ[lane*8 +: 8] & ~LOCAL_WR_MASK[lane*8 +: 8]))
			: localQ[lane*8 +: 8];
	end

	// Straps are caught on the first edge after reset release
	assign strapLoad = !strapDoneQ;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			strapDoneQ <= 1'b0;
		end else begin
			strapDoneQ <= 1'b1;
		end
	end

	// Local ability word, driven straight to the negotiation engine
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			localQ <= aar_local_t'(LOCAL_RESET);
		end else if (strapLoad) begin
			localQ[STRAP_LSB +: STRAP_W] <= strapAbility;
		end else if (commitLocal) begin
			localQ <= aar_local_t'(localWr);
		end
	end

	assign advertAbility = localQ;

	// Partner word frozen after completion unless next pages run
	assign capPartner = partnerPageValid && (!anComplete || NEXT_PAGE_SUPPORT);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			partnerQ <= aar_partner_t'(PARTNER_RESET);
		end else if (capPartner) begin
			partnerQ <= aar_partner_t'(partnerPageIn & PARTNER_MASK);
		end
	end

	// Latched-high status bits; a new event wins over the read clear
	assign clrExp = arFire && (arIdx == IDX_W'(IDX_EXP));

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			faultQ  <= 1'b0;
			pageRxQ <= 1'b0;
		end else begin
			faultQ  <= parallelDetectFault || (faultQ && !clrExp);
			pageRxQ <= capPartner || (pageRxQ && !clrExp);
		end
	end

	// Partner status levels
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			lpNpQ <= 1'b0;
			lpAnQ <= 1'b0;
		end else begin
			lpNpQ <= partnerNpAble;
			lpAnQ <= partnerAnAble;
		end
	end

	// Expansion word: fixed ones plus live status
	always_comb begin
		expWord                = EXP_CONST;
		expWord[EXP_FAULT_BIT] = faultQ;
		expWord[EXP_LPNP_BIT]  = lpNpQ;
		expWord[EXP_PAGE_BIT]  = pageRxQ;
		expWord[EXP_LPAN_BIT]  = lpAnQ;
	end

	// Read multiplexer
	always_comb begin
		rdMux = 16'h0000;
		rdHit = 1'b1;
		if (arIdx == IDX_W'(IDX_LOCAL)) begin
			rdMux = localQ;
		end else if (arIdx == IDX_W'(IDX_PARTNER)) begin
			rdMux = partnerQ;
		end else if (arIdx == IDX_W'(IDX_EXP)) begin
			rdMux = expWord;
		end else begin
			rdHit = 1'b0;
		end
	end

	// Read response; unmapped reads return zero with an error
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rvalidQ <= 1'b0;
			rrespQ  <= RESP_OKAY;
			rdataQ  <= 32'h00000000;
		end else if (arFire) begin
			rvalidQ <= 1'b1;
			rrespQ  <= rdHit ? RESP_OKAY : RESP_SLVERR;
			rdataQ  <= {16'h0000, rdMux};
		end else if (rready) begin
			rvalidQ <= 1'b0;
		end
	end

	// Checks on the register behaviour
	a_np_adv_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[1] |=> advertAbility.localNpRequest == $past(wDataQ[15]))
		else $error("next page advertise bit did not take write");

	a_fault_adv_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[1] |=> advertAbility.localRemoteFaultFlag == $past(wDataQ[13]))
		else $error("remote fault advertise bit did not take write");

	a_local_flow_ctrl_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[1] |=> {advertAbility.localAsymFlowCtrl, advertAbility.localFlowCtrl}
			== $past(wDataQ[11:10]))
		else $error("pause advertise bits did not take write");

	a_t4_storage_only: assert property (@(posedge clock) disable iff (!nrst)
		!(commitLocal && wStrbQ[1]) |=> $stable(advertAbility.localT4Cap))
		else $error("four-pair bit changed without a write");

	a_strap_load: assert property (@(posedge clock) disable iff (!nrst)
		$rose(strapDoneQ) |-> advertAbility[STRAP_LSB +: STRAP_W] == $past(strapAbility))
		else $error("strap values not loaded after reset");

	a_selector_reset: assert property (@(posedge clock) disable iff (!nrst)
		strapLoad |-> advertAbility.localTechSelector == 5'h01 && advertAbility[15:9] == 7'h00)
		else $error("local word not at reset value");

	a_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
		$rose(rvalidQ) |-> rdataQ[31:16] == 16'h0000
			&& !($past(arIdx) == IDX_W'(IDX_LOCAL) && rdataQ[14])
			&& !($past(arIdx) == IDX_W'(IDX_PARTNER) && rdataQ[12]))
		else $error("reserved bit read as one");

	a_partner_capture: assert property (@(posedge clock) disable iff (!nrst)
		capPartner |=> partnerQ == ($past(partnerPageIn) & PARTNER_MASK))
		else $error("partner word not captured");

	a_partner_readback: assert property (@(posedge clock) disable iff (!nrst)
		arFire && arIdx == IDX_W'(IDX_PARTNER) |=> rvalidQ && rdataQ[15:0] == $past(partnerQ))
		else $error("partner word read back wrong");

	a_exp_fixed_bits: assert property (@(posedge clock) disable iff (!nrst)
		arFire && arIdx == IDX_W'(IDX_EXP) |=> rdataQ[15:7] == 9'h000 && rdataQ[6:5] == 2'h3 && rdataQ[2])
		else $error("expansion fixed bits wrong");

	a_fault_latch: assert property (@(posedge clock) disable iff (!nrst)
		parallelDetectFault |=> faultQ ##0 (faultQ || clrExp) [*1])
		else $error("parallel detect fault not latched");

	a_fault_clear: assert property (@(posedge clock) disable iff (!nrst)
		clrExp && !parallelDetectFault |=> !faultQ && rdataQ[EXP_FAULT_BIT] == $past(faultQ))
		else $error("parallel detect fault not cleared by read");

	// Storage, status and bus timing
	a_rsvd_local_zero: assert property (@(posedge clock) disable iff (!nrst)
		!advertAbility.reservedZero)
		else $error("local reserved bit set");

	a_spare_bit_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[1] |=> advertAbility.localSpareBit == $past(wDataQ[12]))
		else $error("spare bit did not take write");

	a_t4_bit_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[1] |=> advertAbility.localT4Cap == $past(wDataQ[9]))
		else $error("four-pair bit did not take write");

	a_fast_full_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[1] |=> advertAbility.localFastFullCap == $past(wDataQ[8]))
		else $error("fast full bit did not take write");

	a_low_lane_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[0] |=> advertAbility[7:5] == $past(wDataQ[7:5]))
		else $error("fast half or ten bits did not take write");

	a_selector_write: assert property (@(posedge clock) disable iff (!nrst)
		commitLocal && wStrbQ[0] |=> advertAbility.localTechSelector == $past(wDataQ[4:0]))
		else $error("selector did not take write");

	a_local_hold: assert property (@(posedge clock) disable iff (!nrst)
		!commitLocal && !strapLoad |=> $stable(advertAbility))
		else $error("local word changed without a write");

	a_local_readback: assert property (@(posedge clock) disable iff (!nrst)
		arFire && arIdx == IDX_W'(IDX_LOCAL) |=> rvalidQ && rdataQ[15:0] == $past(advertAbility))
		else $error("local word read back wrong");

	a_write_resp: assert property (@(posedge clock) disable iff (!nrst)
		commit |=> bvalidQ)
		else $error("write response missing");

	a_rsvd_partner_zero: assert property (@(posedge clock) disable iff (!nrst)
		!partnerQ.reservedZero)
		else $error("partner reserved bit set");

	a_partner_hold: assert property (@(posedge clock) disable iff (!nrst)
		!capPartner |=> $stable(partnerQ))
		else $error("partner word changed without a page");

	a_page_latch: assert property (@(posedge clock) disable iff (!nrst)
		capPartner |=> pageRxQ)
		else $error("page received flag not set");

	a_status_levels: assert property (@(posedge clock) disable iff (!nrst)
		nrst |=> lpNpQ == $past(partnerNpAble) && lpAnQ == $past(partnerAnAble))
		else $error("partner status levels not followed");

	a_fault_hold: assert property (@(posedge clock) disable iff (!nrst)
		faultQ && !clrExp |=> faultQ)
		else $error("parallel detect fault dropped without read");

	a_unmapped_read: assert property (@(posedge clock) disable iff (!nrst)
		arFire && !rdHit |=> rrespQ == RESP_SLVERR && rdataQ == 32'h00000000)
		else $error("unmapped read not refused");

endmodule

// *** aar_pkg.sv ***
package aar_pkg;

	// Register indices; byte address is four times the index
	localparam int unsigned IDX_LOCAL   = 4;
	localparam int unsigned IDX_PARTNER = 5;
	localparam int unsigned IDX_EXP     = 6;

	// Values after reset
	localparam logic [15:0] LOCAL_RESET   = 16'h0001;
	localparam logic [15:0] PARTNER_RESET = 16'h0000;
	localparam logic [15:0] EXP_RESET     = 16'h0064;

	// Writable bits of the local ability word, bit 14 held at zero
	localparam logic [15:0] LOCAL_WR_MASK = 16'hbfff;
	// Bit 12 of the partner word is reserved
	localparam logic [15:0] PARTNER_MASK  = 16'hefff;

	// Field positions
	localparam int unsigned STRAP_LSB     = 5;
	localparam int unsigned STRAP_W       = 4;
	localparam int unsigned EXP_FAULT_BIT = 4;
	localparam int unsigned EXP_LPNP_BIT  = 3;
	localparam int unsigned EXP_PAGE_BIT  = 1;
	localparam int unsigned EXP_LPAN_BIT  = 0;
	localparam logic [15:0] EXP_CONST     = 16'h0064;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Local advertisement word as sent to the partner
	typedef struct packed {
		logic       localNpRequest;
		logic       reservedZero;
		logic       localRemoteFaultFlag;
		logic       localSpareBit;
		logic       localAsymFlowCtrl;
		logic       localFlowCtrl;
		logic       localT4Cap;
		logic       localFastFullCap;
		logic       localFastHalfCap;
		logic       localTenFullCap;
		logic       localTenHalfCap;
		logic [4:0] localTechSelector;
	} aar_local_t;

	// Ability word received from the partner
	typedef struct packed {
		logic       partnerNpRequest;
		logic       partnerAck;
		logic       partnerRemoteFaultFlag;
		logic       reservedZero;
		logic       partnerAsymFlowCtrl;
		logic       partnerFlowCtrl;
		logic       partnerT4Cap;
		logic       partnerFastFullCap;
		logic       partnerFastHalfCap;
		logic       partnerTenFullCap;
		logic       partnerTenHalfCap;
		logic [4:0] partnerTechSelector;
	} aar_partner_t;

endpackage

// *** aar_link_partner.sv ***
module aar_link_partner
	import aar_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         sendReq,
	input  wire aar_partner_t sendWord,
	output      logic         partnerPageValid,
	output      aar_partner_t partnerPageIn
);
	timeunit 1ns;
	timeprecision 1ns;

	// One-cycle page strobe, word scrambled between pages
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			partnerPageValid <= 1'b0;
			partnerPageIn    <= '0;
		end else begin
			partnerPageValid <= sendReq;
			partnerPageIn    <= sendReq ? sendWord : ~partnerPageIn; // Not held outside a page
		end
	end
endmodule

// *** aar_ability_regs_tb_top.sv ***
module aar_ability_regs_tb_top
	import aar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic               clock = 1'b0;
	logic               nrst = 1'b0;
	logic [7:0]         awaddr = '0, araddr = '0;
	logic               awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0]        wdata = '0;
	logic [3:0]         wstrb = '0;
	logic               bready = 1'b1, rready = 1'b1;
	logic               awready, wready, bvalid, arready, rvalid;
	logic [1:0]         bresp, rresp;
	logic [31:0]        rdata;
	logic [3:0]         strapAbility = 4'hf;
	logic               anComplete = 1'b0, parallelDetectFault = 1'b0;
	logic               partnerNpAble = 1'b0, partnerAnAble = 1'b0;
	logic               sendReq = 1'b0, partnerPageValid;
	aar_partner_t       sendWord = '0, partnerPageIn;
	aar_local_t         advertAbility;
	logic [31:0]        seed = 32'h3e635a5f, v, d;
	logic [15:0]        shadow;
	logic [1:0]         r;
	int                 n_errors = 0, compares = 0;

	aar_ability_regs dut (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .strapAbility(strapAbility), .anComplete(anComplete),
		.partnerPageValid(partnerPageValid), .partnerPageIn(partnerPageIn),
		.parallelDetectFault(parallelDetectFault), .partnerNpAble(partnerNpAble),
		.partnerAnAble(partnerAnAble), .advertAbility(advertAbility));

	aar_link_partner partner (.clock(clock), .nrst(nrst), .sendReq(sendReq), .sendWord(sendWord),
		.partnerPageValid(partnerPageValid), .partnerPageIn(partnerPageIn));

	always #25 clock = ~clock;

	function automatic logic [31:0] nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected local word after a strobed write
	function automatic logic [15:0] expLocal(input logic [15:0] old, input logic [15:0] w, input logic [3:0] s);
		return {s[1] ? w[15:8] : old[15:8], s[0] ? w[7:0] : old[7:0]} & LOCAL_WR_MASK;
	endfunction

	// Expected expansion word from latched events and partner levels
	function automatic logic [15:0] expExp(input logic f, input logic p, input logic n, input logic a);
		return EXP_CONST | {11'h0, f, n, 1'b0, p, a};
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic axWrite(input logic [7:0] a, input logic [15:0] w, input logic [3:0] s, output logic [1:0] rs);
		awaddr <= a;
		wdata <= {16'h0, w};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rs = bresp;
	endtask

	task automatic axRead(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		rs = rresp;
	endtask

	task automatic wrap_up();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog against a stalled handshake
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		wrap_up();
	end

	initial begin
		v = nextRand();
		strapAbility <= v[3:0];
		repeat (16) @(posedge clock);
		chk("advert in reset", advertAbility, LOCAL_RESET);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		shadow = LOCAL_RESET | (16'(strapAbility) << STRAP_LSB);
		axRead(8'(IDX_LOCAL * 4), d, r);
		chk("local after reset", d, {16'h0, shadow});
		chk("read resp", r, RESP_OKAY);
		axRead(8'(IDX_PARTNER * 4), d, r);
		chk("partner after reset", d, {16'h0, PARTNER_RESET});
		axRead(8'(IDX_EXP * 4), d, r);
		chk("expansion after reset", d, {16'h0, EXP_RESET});
		// Random words, then all ones, then a low lane only
		for (int i = 0; i < 10; i++) begin
			v = nextRand();
			if (i == 8) v = 32'h0000ffff;
			if (i == 9) v = 32'h0;
			axWrite(8'(IDX_LOCAL * 4), v[15:0], (i == 9) ? 4'h1 : 4'h3, r);
			shadow = expLocal(shadow, v[15:0], (i == 9) ? 4'h1 : 4'h3);
			chk("write resp", r, RESP_OKAY);
			chk("advert out", advertAbility, shadow);
			axRead(8'(IDX_LOCAL * 4), d, r);
			chk("local read", d, {16'h0, shadow});
		end
		axWrite(8'(IDX_PARTNER * 4), 16'hffff, 4'h3, r);
		chk("partner write resp", r, RESP_OKAY);
		axRead(8'(IDX_PARTNER * 4), d, r);
		chk("partner read only", d, 32'h0);
		axWrite(8'h40, 16'h1234, 4'h3, r);
		chk("unmapped write", r, RESP_SLVERR);
		axRead(8'h40, d, r);
		chk("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
		// Pages before and after completion
		for (int j = 0; j < 2; j++) begin
			anComplete <= j[0];
			v = nextRand();
			sendWord <= v[15:0];
			sendReq <= 1'b1; // Fresh exchange after local writes
			@(posedge clock);
			sendReq <= 1'b0;
			repeat (3) @(posedge clock);
			axRead(8'(IDX_PARTNER * 4), d, r);
			chk("partner page", d, {16'h0, v[15:0] & PARTNER_MASK});
			axRead(8'(IDX_EXP * 4), d, r);
			chk("page latch", d, {16'h0, expExp(0, 1, 0, 0)});
			axRead(8'(IDX_EXP * 4), d, r);
			chk("page latch cleared", d, {16'h0, expExp(0, 0, 0, 0)});
		end
		partnerNpAble <= 1'b1;
		partnerAnAble <= 1'b1;
		parallelDetectFault <= 1'b1;
		@(posedge clock);
		parallelDetectFault <= 1'b0;
		repeat (2) @(posedge clock);
		axRead(8'(IDX_EXP * 4), d, r);
		chk("fault latch", d, {16'h0, expExp(1, 0, 1, 1)});
		axRead(8'(IDX_EXP * 4), d, r);
		chk("fault cleared", d, {16'h0, expExp(0, 0, 1, 1)});
		// Event only on the edge of a clearing read: the event wins
		parallelDetectFault <= 1'b1;
		fork
			axRead(8'(IDX_EXP * 4), d, r);
			begin
				@(posedge clock);
				parallelDetectFault <= 1'b0;
			end
		join
		chk("fault with read", d, {16'h0, expExp(0, 0, 1, 1)});
		axRead(8'(IDX_EXP * 4), d, r);
		chk("fault set wins", d, {16'h0, expExp(1, 0, 1, 1)});
		axRead(8'(IDX_EXP * 4), d, r);
		chk("fault cleared again", d, {16'h0, expExp(0, 0, 1, 1)});
		wrap_up();
	end
endmodule
